// *** common/sfp_map.svh ***
// Purpose: register offsets, field positions and reset values
// Assumes: byte addresses on an 8-bit register port
// Notes: definitions only
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

// Register offsets
`define SFP_A_CTRL 8'h00
`define SFP_A_STAT 8'h04
`define SFP_A_NVCFG 8'h08
`define SFP_A_VCFG 8'h0C
`define SFP_A_EVCFG 8'h10
`define SFP_A_RXD 8'h14
`define SFP_A_TXD 8'h18
`define SFP_A_ICR 8'h1C

// Control fields
`define SFP_B_RESCUE 2
`define SFP_B_BOOT 3

// Status write fields
`define SFP_B_BUSY 0
`define SFP_B_VPPCYC 1

// Nonvolatile and enhanced volatile protocol bits
`define SFP_NV_DUAL 2
`define SFP_NV_QUAD 3
`define SFP_EV_DUAL 6
`define SFP_EV_QUAD 7

// Reset values and counts
`define SFP_NV_RESET 16'hFFFF
`define SFP_ZERO16 16'h0000
`define SFP_BYTE_BITS 4'h8
`define SFP_OE_ONE 4'h2
`define SFP_OE_TWO 4'h3
`define SFP_OE_FOUR 4'hF

`endif

// *** common/sfp_pkg.sv ***
// Purpose: types shared by the serial protocol front end
// Assumes: one clock domain, sys_clk
// Notes: constants live in sfp_map.svh
package sfp_pkg;

  // Active transfer protocol
  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} sfp_proto_t;

  // Number of io lines used per clock
  typedef enum logic [1:0] {LANE1, LANE2, LANE4} sfp_lanes_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wrData;
    logic wr;
    logic rd;
  } sfp_req_t;

  // Serial pins seen by the block
  typedef struct packed {
    logic chipSelN;
    logic spiClk;
    logic vpp;
    logic [3:0] io;
  } sfp_pins_t;

  // Driven io lines
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sfp_drive_t;

endpackage

// *** logic/sfp_pin_sync.sv ***
// Purpose: two-stage synchroniser for the serial pins
// Assumes: pins are asynchronous to sys_clk
// Notes: first stage feeds only the second stage
module sfp_pin_sync
  import sfp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sfp_pins_t pinsIn,
  output sfp_pins_t pinsOut
);

  // Both stages in one struct
  typedef struct packed {
    sfp_pins_t meta;
    sfp_pins_t stable;
  } sfp_sync_t;

  sfp_sync_t s;
  sfp_sync_t next_s;

  // Shift pins through two flops; idle deselected
  always_comb begin
    next_s.meta = pinsIn;
    next_s.stable = s.meta;
    if (!rst_n) begin
      next_s = '0;
      next_s.meta.chipSelN = 1'b1;
      next_s.stable.chipSelN = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  assign pinsOut = s.stable;

endmodule

// *** logic/sfp_protocol_select.sv ***
// Purpose: serial front end with extended, two-line and four-line protocols
// Assumes: serial clock and pins are oversampled by the 100 MHz sys_clk
// Assumes: serial clock below a sixth of sys_clk, edges seen late
// Notes: command decode and array access sit behind the register port
//
// Design decisions made here: the address map and strobed register access.
`include "sfp_map.svh"
module sfp_protocol_select
  import sfp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sfp_req_t regReq,
  output logic [15:0] regRdData,
  input wire sfp_pins_t pins,
  output sfp_drive_t ioDrive
);

  // Whole block state
  // One register copy keeps reset and next-state logic together
  typedef struct packed {
    logic sckPrev;
    // Configuration and protocol
    logic [15:0] nvCfg;
    logic [15:0] icr;
    sfp_proto_t proto;
    logic tempExt;
    logic busy;
    logic vppCycle;
    sfp_lanes_t extLanes;
    // Receive path
    logic cmdPhase;
    logic [7:0] rxShift;
    logic [3:0] rxCnt;
    logic [7:0] rxByte;
    logic rxCmd;
    logic rxValid;
    // Transmit path
    logic [7:0] txBuf;
    logic txFull;
    logic [7:0] txShift;
    logic [3:0] txCnt;
    // Registered outputs
    sfp_drive_t drive;
    logic [15:0] rdData;
  } sfp_state_t;

  sfp_state_t s;
  sfp_state_t next_s;
  sfp_pins_t syncPins;

  // Pins pass two flops before use
  // Edges reach the logic two to three sys_clk cycles late
  // Serial clock must stay well below a sixth of sys_clk
  sfp_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pinsIn(pins),
    .pinsOut(syncPins)
  );

  // Lines moved per serial clock
  // Reserved lane code counts as one line but moves no bits, never a hang
  function automatic logic [3:0] laneBits(input sfp_lanes_t l);
    unique case (l)
      LANE1: laneBits = 4'h1;
      LANE2: laneBits = 4'h2;
      LANE4: laneBits = 4'h4;
      default: laneBits = 4'h1;
    endcase
  endfunction

  // Shift in one clock worth of bits, most significant first
  // Unused io lines ignored in narrow widths
  function automatic logic [7:0] shiftIn(input logic [7:0] sh, input logic [3:0] io,
                                         input sfp_lanes_t l);
    unique case (l)
      LANE1: shiftIn = {sh[6:0], io[0]};
      LANE2: shiftIn = {sh[5:0], io[1:0]};
      LANE4: shiftIn = {sh[3:0], io[3:0]};
      default: shiftIn = sh;
    endcase
  endfunction

  // Top bits of a byte onto the io lines
  // Single-line output on io_line_1; io_line_0 stays an input
  function automatic sfp_drive_t driveOut(input logic [7:0] sh, input sfp_lanes_t l);
    driveOut = '0;
    unique case (l)
      LANE1: begin
        driveOut.out[1] = sh[7];
        driveOut.oe = `SFP_OE_ONE;
      end
      LANE2: begin
        driveOut.out[1:0] = sh[7:6];
        driveOut.oe = `SFP_OE_TWO;
      end
      LANE4: begin
        driveOut.out = sh[7:4];
        driveOut.oe = `SFP_OE_FOUR;
      end
      default: driveOut = '0;
    endcase
  endfunction

  // Boot protocol from nonvolatile bits, four-line first
  // Both enables low is undefined; four-line wins by choice
  function automatic sfp_proto_t protoFromNv(input logic [15:0] nv);
    if (!nv[`SFP_NV_QUAD])
      protoFromNv = PROTO_QUAD;
    else if (!nv[`SFP_NV_DUAL])
      protoFromNv = PROTO_DUAL;
    else
      protoFromNv = PROTO_EXT;
  endfunction

  // Edge strobes and lane choices for this cycle
  logic sckRise;
  logic sckFall;
  sfp_lanes_t cmdLanes;
  sfp_lanes_t dataLanes;
  sfp_lanes_t curLanes;
  logic [3:0] rxNext;
  logic [7:0] txNextSh;

  // Lane selection for the current phase
  // Phase flag picks the width for the next edge
  // Protocol change mid-byte applies from the next edge
  always_comb begin
    // command on one line in extended
    cmdLanes = LANE1;
    if (s.proto == PROTO_DUAL)
      cmdLanes = LANE2;
    if (s.proto == PROTO_QUAD && !s.tempExt)
      cmdLanes = LANE4;
    // address and data width per command
    if (s.proto == PROTO_EXT || s.tempExt)
      dataLanes = s.extLanes;
    else
      dataLanes = cmdLanes;
    curLanes = s.cmdPhase ? cmdLanes : dataLanes;
  end

  // Next state
  // Later assignments win: set beats clear, reset beats all
  always_comb begin
    next_s = s;
    rxNext = 4'h0;
    txNextSh = 8'h00;
    // Prev starts low; an idle-high clock shows one rise after reset
    // That rise lands while deselected, so nothing is shifted
    // edges found from level change, either idle level
    // same edge logic for every protocol
    sckRise = syncPins.spiClk & ~s.sckPrev;
    sckFall = ~syncPins.spiClk & s.sckPrev;
    next_s.sckPrev = syncPins.spiClk;
    next_s.rdData = `SFP_ZERO16;

    // Register reads, data one cycle later
    // Read data stand one cycle, then return to zero
    if (regReq.rd) begin
      unique case (regReq.addr)
        `SFP_A_CTRL: next_s.rdData = {14'h0000, s.extLanes};
        `SFP_A_STAT: next_s.rdData = {8'h00, s.txFull, s.rxValid, ~syncPins.chipSelN,
                                      s.tempExt, s.proto, s.vppCycle, s.busy};
        `SFP_A_NVCFG: next_s.rdData = s.nvCfg;
        // internal register on the core port only
        `SFP_A_ICR: next_s.rdData = s.icr;
        `SFP_A_RXD: begin
          next_s.rdData = {7'h00, s.rxCmd, s.rxByte};
          // Clear loses to a byte finishing this cycle
          next_s.rxValid = 1'b0;
        end
        default: next_s.rdData = `SFP_ZERO16;
      endcase
    end

    // Register writes from the command core
    if (regReq.wr) begin
      unique case (regReq.addr)
        `SFP_A_CTRL: begin
          next_s.extLanes = sfp_lanes_t'(regReq.wrData[1:0]);
          if (regReq.wrData[`SFP_B_RESCUE]) begin
            next_s.proto = PROTO_EXT;
            next_s.tempExt = 1'b0;
          end
          // Nonvolatile value acts only here, never on its own write
          // boot reloads internal configuration
          if (regReq.wrData[`SFP_B_BOOT]) begin
            next_s.icr = s.nvCfg;
            next_s.proto = protoFromNv(s.nvCfg);
            next_s.tempExt = 1'b0;
          end
        end
        `SFP_A_STAT: begin
          next_s.busy = regReq.wrData[`SFP_B_BUSY];
          next_s.vppCycle = regReq.wrData[`SFP_B_VPPCYC];
        end
        // stored only, acts at next boot
        `SFP_A_NVCFG: next_s.nvCfg = regReq.wrData;
        `SFP_A_VCFG: next_s.icr[7:0] = regReq.wrData[7:0];
        `SFP_A_EVCFG: begin
          // An enhanced write drops a temporary extended state unless a Vpp cycle in four-line sets it again this cycle
          // Protocol decoded from the written value
          // enhanced write updates internal now
          next_s.icr[15:8] = regReq.wrData[7:0];
          next_s.tempExt = 1'b0;
          // bit 7 high, bit 6 low gives two-line
          if (!regReq.wrData[`SFP_EV_QUAD])
            next_s.proto = PROTO_QUAD;
          else if (!regReq.wrData[`SFP_EV_DUAL])
            next_s.proto = PROTO_DUAL;
          else
            next_s.proto = PROTO_EXT;
        end
        `SFP_A_TXD: begin
          // Set here beats the clear of a launch this cycle
          next_s.txBuf = regReq.wrData[7:0];
          next_s.txFull = 1'b1;
        end
        // Unmapped writes change nothing
        default: next_s.txFull = next_s.txFull;
      endcase
    end

    // Set needs the supply high, clear needs it low, so they never meet
    // Vpp cycle in four-line opens extended
    if (s.proto == PROTO_QUAD && s.busy && s.vppCycle && syncPins.vpp)
      next_s.tempExt = 1'b1;
    if (!syncPins.vpp)
      next_s.tempExt = 1'b0;

    // Deselect wins over any edge seen this cycle
    // A cut byte is dropped; the next select starts a command
    // deselect resets phase and releases io
    if (syncPins.chipSelN) begin
      next_s.cmdPhase = 1'b1;
      next_s.rxCnt = 4'h0;
      next_s.txCnt = 4'h0;
      next_s.drive = '0;
    end else begin
      if (sckRise) begin
        next_s.rxShift = shiftIn(s.rxShift, syncPins.io, curLanes);
        rxNext = s.rxCnt + laneBits(curLanes);
        // Counted in bits, so a byte is eight at any width
        if (rxNext >= `SFP_BYTE_BITS) begin
          // Byte complete: hand over, leave the command phase
          next_s.rxByte = next_s.rxShift;
          next_s.rxCmd = s.cmdPhase;
          next_s.rxValid = 1'b1;
          next_s.cmdPhase = 1'b0;
          next_s.rxCnt = 4'h0;
        end else begin
          next_s.rxCnt = rxNext;
        end
      end
      if (sckFall) begin
        // New byte only at a byte boundary, so a late load waits
        if (s.txCnt == 4'h0) begin
          if (s.txFull) begin
            next_s.txFull = regReq.wr && regReq.addr == `SFP_A_TXD;
            next_s.drive = driveOut(s.txBuf, curLanes);
            txNextSh = s.txBuf << laneBits(curLanes);
            next_s.txShift = txNextSh;
            next_s.txCnt = `SFP_BYTE_BITS - laneBits(curLanes);
          end else begin
            // Nothing pending: lines released, not held stale
            next_s.drive = '0;
          end
        end else begin
          // Slices move top first, matching the receive order
          next_s.drive = driveOut(s.txShift, curLanes);
          txNextSh = s.txShift << laneBits(curLanes);
          next_s.txShift = txNextSh;
          // Last slice: counter stops at zero for the next byte
          if (s.txCnt > laneBits(curLanes))
            next_s.txCnt = s.txCnt - laneBits(curLanes);
          else
            next_s.txCnt = 4'h0;
        end
      end
    end

    // Last in the process, so reset overrides every path above
    // power-on loads defaults and extended
    if (!rst_n) begin
      next_s = '0;
      next_s.nvCfg = `SFP_NV_RESET;
      next_s.icr = `SFP_NV_RESET;
      next_s.proto = protoFromNv(`SFP_NV_RESET);
      next_s.extLanes = LANE1;
      next_s.cmdPhase = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  // Outputs straight from flops
  // No logic after the flops, so pins see clean edges
  assign regRdData = s.rdData;
  assign ioDrive = s.drive;

endmodule

// *** testbench/sfp_protocol_select_monitor.sv ***
// Purpose: port checker for the protocol front end
// Assumes: single sys_clk domain
// Notes: bound to the design below
`include "sfp_map.svh"
module sfp_mon
  import sfp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sfp_req_t regReq,
  input wire logic [15:0] regRdData,
  input wire sfp_pins_t pins,
  input wire sfp_drive_t ioDrive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Read data only in its slot
  property p_rdIdle; !$past(regReq.rd) |-> regRdData == 16'h0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  property p_release; pins.chipSelN [*5] |-> ioDrive.oe == 4'h0; endproperty
  a_release: assert property (p_release) else $error("io driven while deselected");
  property p_oeSet; ioDrive.oe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
  a_oeSet: assert property (p_oeSet) else $error("illegal lane enables");
  property p_launch; $changed(ioDrive.out) && ioDrive.oe != 4'h0
    |-> !$past(pins.spiClk, 2) || !$past(pins.spiClk, 3) || !$past(pins.spiClk, 4); endproperty
  a_launch: assert property (p_launch) else $error("output not on clock fall");
  // Register write followed by read
  property p_nvKeep; regReq.wr && regReq.addr == `SFP_A_NVCFG ##1 regReq.rd && regReq.addr == `SFP_A_NVCFG
    |=> regRdData == $past(regReq.wrData, 2); endproperty
  a_nvKeep: assert property (p_nvKeep) else $error("nonvolatile value lost");
  property p_vcfgIcr; regReq.wr && regReq.addr == `SFP_A_VCFG ##1 regReq.rd && regReq.addr == `SFP_A_ICR
    |=> regRdData[7:0] == $past(regReq.wrData[7:0], 2); endproperty
  a_vcfgIcr: assert property (p_vcfgIcr) else $error("volatile copy missing");
  property p_evQuad; regReq.wr && regReq.addr == `SFP_A_EVCFG && !regReq.wrData[7]
    ##1 regReq.rd && regReq.addr == `SFP_A_STAT |=> regRdData[3:2] == 2'h2; endproperty
  a_evQuad: assert property (p_evQuad) else $error("four-line not entered");
  property p_evDual; regReq.wr && regReq.addr == `SFP_A_EVCFG && regReq.wrData[7:6] == 2'b10
    ##1 regReq.rd && regReq.addr == `SFP_A_STAT |=> regRdData[3:2] == 2'h1; endproperty
  a_evDual: assert property (p_evDual) else $error("two-line not entered");
  property p_rescue; regReq.wr && regReq.addr == `SFP_A_CTRL && regReq.wrData[3:2] == 2'b01
    ##1 regReq.rd && regReq.addr == `SFP_A_STAT |=> regRdData[3:2] == 2'h0; endproperty
  a_rescue: assert property (p_rescue) else $error("rescue not to extended");
endmodule
bind sfp_protocol_select sfp_mon mon (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
  .regRdData(regRdData), .pins(pins), .ioDrive(ioDrive));

// *** testbench/sfp_host_model.sv ***
// Purpose: serial host driving the link pins
// Assumes: 160 ns serial clock, modes 0 and 3
// Notes: device wins an io line it enables
module sfp_host_model
  import sfp_pkg::*;
(
  input wire logic vpp,
  input wire sfp_drive_t ioDrive,
  output sfp_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cs = 1'b1;
  logic clk = 1'b0;
  logic cpol = 1'b0;
  logic [3:0] hostIo = 4'h0;
  logic [3:0] io;
  // Wire level from both drivers
  assign io = (ioDrive.oe & ioDrive.out) | (~ioDrive.oe & hostIo);
  assign pins = '{cs, clk, vpp, io};
  task automatic startFrame(input logic mode);
    cpol = mode;
    clk = mode;
    #40 cs = 1'b0;
    #40;
  endtask
  // set before rise, sample at rise
  task automatic xfer(input logic [7:0] tx, input int lanes, output logic [7:0] rx);
    logic [7:0] sh;
    logic [3:0] got;
    sh = tx;
    rx = 8'h00;
    for (int i = 0; i < 8; i += lanes) begin
      clk = 1'b0;
      hostIo = 4'(sh[7:4] >> (4 - lanes));
      sh = 8'(sh << lanes);
      #80 clk = 1'b1;
      got = (lanes == 1) ? {3'b000, io[1]} : io & 4'((1 << lanes) - 1);
      rx = 8'(rx << lanes) | {4'h0, got};
      #80;
    end
  endtask
  task automatic endFrame();
    #80 clk = cpol;
    #40 cs = 1'b1;
    hostIo = ~hostIo;
    #80;
  endtask
endmodule

// *** testbench/sfp_protocol_select_tb_top.sv ***
// Purpose: self-checking bench for the protocol front end
// Assumes: link clock made by the host model
// Notes: rows walk protocol selection
`include "sfp_map.svh"
module sfp_protocol_select_tb_top
  import sfp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [1:0] p;} sfp_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic vpp = 1'b0; // Defined level, never floating
  sfp_req_t regReq = '0;
  logic [15:0] regRdData;
  sfp_pins_t pins;
  sfp_drive_t ioDrive;
  logic [7:0] rx;
  int badCount = 0;
  int totalChecks = 0;
  sfp_row_t rows [11] = '{'{`SFP_A_EVCFG, 16'h00FF, 2'd0}, '{`SFP_A_EVCFG, 16'h00BF, 2'd1},
    '{`SFP_A_EVCFG, 16'h007F, 2'd2}, '{`SFP_A_CTRL, 16'h0004, 2'd0}, '{`SFP_A_NVCFG, 16'hFFFB, 2'd0},
    '{`SFP_A_CTRL, 16'h0008, 2'd1}, '{`SFP_A_NVCFG, 16'hFFF7, 2'd1}, '{`SFP_A_CTRL, 16'h0008, 2'd2},
    '{`SFP_A_NVCFG, 16'hFFF3, 2'd2}, '{`SFP_A_CTRL, 16'h0008, 2'd2}, '{`SFP_A_EVCFG, 16'h00FF, 2'd0}};
  sfp_protocol_select uut (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
    .pins(pins), .ioDrive(ioDrive));
  sfp_host_model host (.vpp(vpp), .ioDrive(ioDrive), .pins(pins));
  // System clock
  always #5 sys_clk = ~sys_clk;
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write, then read in the next cycle
  task automatic bus(input logic [7:0] wa, input logic [15:0] wd, input logic [7:0] ra,
    input logic [15:0] exp, input logic [15:0] mask);
    @(posedge sys_clk);
    regReq <= '{wa, wd, 1'b1, 1'b0};
    @(posedge sys_clk);
    regReq <= '{ra, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    regReq <= '0;
    #1 chk(regRdData & mask, exp);
  endtask
  task automatic summarize();
    if (badCount == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #300000;
    badCount++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk({8'h00, ioDrive}, 16'h0000);
    bus(8'h20, 16'h1234, `SFP_A_ICR, 16'hFFFF, 16'hFFFF);
    bus(8'h20, 16'h0000, `SFP_A_STAT, 16'h0000, 16'h00FF);
    foreach (rows[i]) bus(rows[i].a, rows[i].d, `SFP_A_STAT, {12'h000, rows[i].p, 2'b00}, 16'h000C);
    bus(`SFP_A_NVCFG, 16'hFFF3, `SFP_A_NVCFG, 16'hFFF3, 16'hFFFF);
    bus(`SFP_A_VCFG, 16'h005A, `SFP_A_ICR, 16'hFF5A, 16'hFFFF);
    for (int m = 0; m < 2; m++) begin
      for (int p = 0; p < 3; p++) begin
        bus(`SFP_A_EVCFG, (p == 0) ? 16'h00FF : (p == 1) ? 16'h00BF : 16'h007F, `SFP_A_STAT,
          16'(p << 2), 16'h000C);
        host.startFrame(m[0]);
        host.xfer(8'h3C, 1 << p, rx);
        bus(`SFP_A_TXD, 16'h00A5, `SFP_A_RXD, 16'h013C, 16'h01FF);
        host.xfer(8'h00, 1 << p, rx);
        host.endFrame();
        chk({8'h00, rx}, 16'h00A5);
      end
    end
    // Deselect in mid-byte
    bus(`SFP_A_EVCFG, 16'h00FF, 8'h20, 16'h0000, 16'hFFFF);
    host.startFrame(1'b0);
    host.xfer(8'hF0, 4, rx);
    host.endFrame();
    host.startFrame(1'b0);
    host.xfer(8'h81, 1, rx);
    bus(8'h20, 16'h0000, `SFP_A_RXD, 16'h0181, 16'h01FF);
    host.endFrame();
    // Extended data phase on two and four lines
    for (int e = 1; e < 3; e++) begin
      bus(`SFP_A_CTRL, 16'(e), `SFP_A_CTRL, 16'(e), 16'hFFFF);
      host.startFrame(1'b0);
      host.xfer(8'h0B, 1, rx);
      bus(`SFP_A_TXD, 16'h005A, `SFP_A_STAT, 16'h00E0, 16'h00E0);
      bus(8'h20, 16'h0000, `SFP_A_RXD, 16'h010B, 16'h01FF);
      host.xfer(8'h00, 2 * e, rx);
      host.endFrame();
      chk({8'h00, rx}, 16'h005A);
      bus(8'h20, 16'h0000, `SFP_A_RXD, 16'h005A, 16'h01FF);
    end
    bus(`SFP_A_CTRL, 16'h0000, `SFP_A_CTRL, 16'h0000, 16'hFFFF);
    // Supply cycle in four-line
    bus(`SFP_A_EVCFG, 16'h007F, `SFP_A_STAT, 16'h0008, 16'h000C);
    @(posedge sys_clk);
    vpp <= 1'b1;
    bus(`SFP_A_STAT, 16'h0003, 8'h20, 16'h0000, 16'hFFFF);
    bus(8'h20, 16'h0000, `SFP_A_STAT, 16'h001B, 16'h001F);
    host.startFrame(1'b1);
    host.xfer(8'hC3, 1, rx);
    bus(8'h20, 16'h0000, `SFP_A_RXD, 16'h01C3, 16'h01FF);
    host.endFrame();
    @(posedge sys_clk);
    vpp <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus(8'h20, 16'h0000, `SFP_A_STAT, 16'h000B, 16'h001F);
    // Second reset in mid-run
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(8'h20, 16'h0000, `SFP_A_NVCFG, 16'hFFFF, 16'hFFFF);
    bus(8'h20, 16'h0000, `SFP_A_STAT, 16'h0000, 16'h00FF);
    summarize();
  end
endmodule
